/* design/channel_counter.sv */
// 16-bit channel counter with optional down counting and wrap detection
`timescale 1ns/10ps
`default_nettype none
module channel_counter #(
  parameter bit CAN_DOWN = 1'b0
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic run,
  input wire logic tick,
  input wire logic phase_mode,
  input wire logic down_req,
  input wire logic load,
  input wire pulse_unit_pkg::count_t load_val,
  output pulse_unit_pkg::count_t cnt,
  output logic dir,
  output logic stepped,
  output logic wrap_up,
  output logic wrap_down
);
  import pulse_unit_pkg::*;
  `include "pulse_unit_defs.svh"

  logic step;
  logic go_down;

  // A bus write takes priority over a count step
  assign step = run & tick & ~load;
  assign go_down = CAN_DOWN & phase_mode & down_req;
  assign wrap_up = step & ~go_down & (cnt == `PU_COUNT_MAX);
  assign wrap_down = step & go_down & (cnt == `PU_COUNT_RESET);

  // Plain modulo arithmetic restarts from zero after an overflow
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      cnt <= `PU_COUNT_RESET;
    else if (load)
      cnt <= load_val;
    else if (step)
      cnt <= go_down ? cnt - `PU_COUNT_ONE : cnt + `PU_COUNT_ONE;
  end

  // Direction shows up outside phase counting, last step direction inside it
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      dir <= 1'b1;
    else if (!(CAN_DOWN & phase_mode))
      dir <= 1'b1;
    else if (step)
      dir <= ~down_req;
  end

  // Marks a fresh count value for compare matching
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      stepped <= 1'b0;
    else
      stepped <= step;
  end

  a_counter_hold:
    assert property (@(posedge clk) disable iff (!rst_n) !run && !load |=> cnt == $past(cnt))
    else $error("counter moved while stopped");
  a_up_step:
    assert property (@(posedge clk) disable iff (!rst_n)
      run && tick && !load && !go_down |=> cnt == $past(cnt) + `PU_COUNT_ONE)
    else $error("counter did not count up by one");
endmodule // channel_counter
`default_nettype wire

/* design/pulse_unit_defs.svh */
// Register indices, field positions, reset values and limits of the timer channel block
`ifndef PULSE_UNIT_DEFS_SVH
`define PULSE_UNIT_DEFS_SVH

`define PU_ADDR_W 3
`define PU_IDX_STATUS_CH0 3'h0
`define PU_IDX_STATUS_CH1 3'h1
`define PU_IDX_STATUS_CH2 3'h2
`define PU_IDX_COUNT_CH0 3'h3
`define PU_IDX_COUNT_CH1 3'h4
`define PU_IDX_COUNT_CH2 3'h5

`define PU_BIT_FLAG_A 0
`define PU_BIT_FLAG_D 3
`define PU_BIT_OVERFLOW 4
`define PU_BIT_UNDERFLOW 5
`define PU_BIT_RSVD6 6
`define PU_BIT_DIRECTION 7

`define PU_STATUS_RESET 8'hc0
`define PU_COUNT_RESET 16'h0000
`define PU_COUNT_MAX 16'hffff
`define PU_COUNT_ONE 16'h0001

`endif

/* design/pulse_unit_pkg.sv */
// Shared types of the timer channel status and counter block
package pulse_unit_pkg;
  typedef logic [15:0] count_t;
  typedef logic [7:0] status_t;
  typedef enum logic {SIZE_BYTE, SIZE_WORD} access_size_t;
endpackage

/* design/status_flag_cell.sv */
// One clear-only status flag with read-as-one tracking
`timescale 1ns/10ps
`default_nettype none
module status_flag_cell (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic set_ev,
  input wire logic rd_seen,
  input wire logic clr_req,
  input wire logic dma_clr,
  output logic flag
);
  logic armed_r;
  logic sw_clear;

  // Zero write only acts once the flag was seen as one
  assign sw_clear = clr_req & armed_r;

  // Set beats any clear in the same cycle so no event is lost
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      flag <= 1'b0;
    else
      flag <= set_ev | (flag & ~sw_clear & ~dma_clr);
  end

  // Arming is dropped once a clear has been honoured
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      armed_r <= 1'b0;
    else if (sw_clear | dma_clr)
      armed_r <= 1'b0;
    else if (rd_seen & flag)
      armed_r <= 1'b1;
  end

  a_set_wins:
    assert property (@(posedge clk) disable iff (!rst_n) set_ev |=> flag)
    else $error("flag lost an event");
  a_clear_guard:
    assert property (@(posedge clk) disable iff (!rst_n) flag && !armed_r && !dma_clr |=> flag)
    else $error("flag cleared without a prior read as one");
  a_write_only_clears:
    assert property (@(posedge clk) disable iff (!rst_n) !flag && !set_ev |=> !flag)
    else $error("flag set without an event");
endmodule // status_flag_cell
`default_nettype wire

/* design/timer_channel_status_and_counter.sv */
// Status flags and counters of the three timer channels with their register access
`timescale 1ns/10ps
`default_nettype none
`include "pulse_unit_defs.svh"
// How it works
// - Three 8-bit status registers, one per channel, each reset to c0.
// - Software writes can only clear flags; zero clears, one keeps.
// - A zero write clears a flag only after software read it as one.
// - Channels 1 and 2 bit 7 shows direction: 0 down, 1 up, reset 1.
// - Channel 0 bit 7 always reads one and ignores writes.
// - Bit 6 is read-only and reads one in every channel.
// - Channels 1 and 2 in phase mode set underflow on 0000 to ffff.
// - Channel 0 bit 5 always reads zero and ignores writes.
// - Overflow flag bit 4 sets when the counter wraps ffff to 0000.
// - Compare flags A to D set when counter equals a compare register.
// - Flags A to D set when input capture loads their register.
// - DMA activation on the selected channel 0 source clears that flag.
// - Channels 1 and 2 bits 3 and 2 read zero and ignore writes.
// - Three 16-bit read/write counters, each cleared to zero on reset.
// - Channels 1 and 2 count down only in phase mode; channel 0 up only.
// - An interrupt request is raised only while flag and enable are both one.
// - After overflow the counter keeps counting up from zero.
// - A counter advances only while its run bit is one.
module timer_channel_status_and_counter (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [`PU_ADDR_W-1:0] bus_addr,
  input wire logic bus_rd,
  input wire logic bus_wr,
  input wire pulse_unit_pkg::access_size_t bus_size,
  input wire logic [15:0] bus_wdata,
  output logic [15:0] bus_rdata,
  input wire logic [2:0] run_bit,
  input wire logic [2:0] count_tick,
  input wire logic [1:0] phase_mode,
  input wire logic [1:0] phase_down,
  input wire logic [127:0] gr_value,
  input wire logic [7:0] gr_is_compare,
  input wire logic [7:0] capture_strobe,
  input wire logic [17:0] irq_enable,
  input wire logic dma_ack,
  input wire logic [1:0] dma_request_select,
  output logic [17:0] irq_req
);
  import pulse_unit_pkg::*;

  localparam int NCH = 3;
  localparam int NFLAG = 6;

  wire logic [NCH-1:0][NFLAG-1:0] flags;
  count_t cnt [NCH];
  logic [NCH-1:0] dir;
  logic [NCH-1:0] stepped;
  logic [NCH-1:0] wrap_up;
  logic [NCH-1:0] wrap_down;
  logic [NCH-1:0] stat_rd;
  logic [NCH-1:0] stat_wr;
  logic [NCH-1:0] cnt_wr;
  status_t stat_val [NCH];
  logic [15:0] rdata_nxt;
  logic [2:0] dma_idx;

  // Bus decode; counters only accept whole-word writes
  always_comb
  begin
    for (int c = 0; c < NCH; c++)
    begin
      stat_rd[c] = bus_rd && (bus_addr == `PU_IDX_STATUS_CH0 + 3'(c));
      stat_wr[c] = bus_wr && (bus_addr == `PU_IDX_STATUS_CH0 + 3'(c));
      cnt_wr[c] = bus_wr && (bus_size == SIZE_WORD) && (bus_addr == `PU_IDX_COUNT_CH0 + 3'(c));
    end
  end

  assign dma_idx = {1'b0, dma_request_select};

  // Per-channel counter and flag cells
  genvar ch;
  genvar b;
  generate
    for (ch = 0; ch < NCH; ch++)
    begin : g_ch
      channel_counter #(
        .CAN_DOWN(ch != 0)
      ) u_counter (
        .clk(clk),
        .rst_n(rst_n),
        .run(run_bit[ch]),
        .tick(count_tick[ch]),
        .phase_mode(ch == 0 ? 1'b0 : phase_mode[ch == 0 ? 0 : ch - 1]),
        .down_req(ch == 0 ? 1'b0 : phase_down[ch == 0 ? 0 : ch - 1]),
        .load(cnt_wr[ch]),
        .load_val(bus_wdata),
        .cnt(cnt[ch]),
        .dir(dir[ch]),
        .stepped(stepped[ch]),
        .wrap_up(wrap_up[ch]),
        .wrap_down(wrap_down[ch])
      );

      for (b = 0; b < NFLAG; b++)
      begin : g_flag
        // Channel 0 has A..D and overflow; others A, B, overflow, underflow
        if ((ch == 0 && b <= `PU_BIT_OVERFLOW) || (ch != 0 && (b <= 1 || b >= `PU_BIT_OVERFLOW)))
        begin : g_live
          localparam int GI = (ch == 0) ? b : 2 + 2 * ch + b;
          logic set_ev;
          logic dma_clr;
          if (b <= `PU_BIT_FLAG_D)
          begin : g_gr
            // Compare match on a fresh count value, or capture strobe
            assign set_ev = (gr_is_compare[GI] & stepped[ch] & (cnt[ch] == gr_value[GI*16 +: 16]))
              | (~gr_is_compare[GI] & capture_strobe[GI]);
          end
          else if (b == `PU_BIT_OVERFLOW)
          begin : g_ovf
            assign set_ev = wrap_up[ch];
          end
          else
          begin : g_udf
            assign set_ev = wrap_down[ch];
          end
          // Only channel 0 sources are DMA-cleared
          assign dma_clr = (ch == 0) && (b <= `PU_BIT_FLAG_D) && dma_ack && (dma_idx == 3'(b));
          status_flag_cell u_flag (
            .clk(clk),
            .rst_n(rst_n),
            .set_ev(set_ev),
            .rd_seen(stat_rd[ch]),
            .clr_req(stat_wr[ch] & ~bus_wdata[b]),
            .dma_clr(dma_clr),
            .flag(flags[ch][b])
          );
        end
        else
        begin : g_rsvd
          assign flags[ch][b] = 1'b0;
        end
      end

      // Bit 6 fixed one, bit 7 direction (always one on channel 0)
      assign stat_val[ch] = {dir[ch], 1'b1, flags[ch]};
    end
  endgenerate

  // Read mux; unmapped indices read as zero
  always_comb
  begin
    rdata_nxt = 16'h0000;
    case (bus_addr)
      `PU_IDX_STATUS_CH0: rdata_nxt = {8'h00, stat_val[0]};
      `PU_IDX_STATUS_CH1: rdata_nxt = {8'h00, stat_val[1]};
      `PU_IDX_STATUS_CH2: rdata_nxt = {8'h00, stat_val[2]};
      `PU_IDX_COUNT_CH0: rdata_nxt = cnt[0];
      `PU_IDX_COUNT_CH1: rdata_nxt = cnt[1];
      `PU_IDX_COUNT_CH2: rdata_nxt = cnt[2];
      default: rdata_nxt = 16'h0000;
    endcase
  end

  // Read data is held until the next read
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      bus_rdata <= 16'h0000;
    else if (bus_rd)
      bus_rdata <= rdata_nxt;
  end

  // Requests are a registered AND of flag and enable
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      irq_req <= 18'h00000;
    else
      irq_req <= flags & irq_enable;
  end

  a_ch0_reserved:
    assert property (@(posedge clk) disable iff (!rst_n)
      bus_rd && bus_addr == `PU_IDX_STATUS_CH0 |=> bus_rdata[7:5] == 3'h6)
    else $error("channel 0 reserved status bits wrong");
  a_ch12_reserved:
    assert property (@(posedge clk) disable iff (!rst_n)
      bus_rd && (bus_addr == `PU_IDX_STATUS_CH1 || bus_addr == `PU_IDX_STATUS_CH2)
      |=> bus_rdata[3:2] == 2'h0 && bus_rdata[6] && bus_rdata[15:8] == 8'h00)
    else $error("channel 1/2 reserved status bits wrong");
  a_overflow_sets:
    assert property (@(posedge clk) disable iff (!rst_n) wrap_up[1] |=> flags[1][`PU_BIT_OVERFLOW])
    else $error("overflow flag missed a wrap");
  a_underflow_sets:
    assert property (@(posedge clk) disable iff (!rst_n)
      wrap_down[2] |=> flags[2][`PU_BIT_UNDERFLOW] && cnt[2] == `PU_COUNT_MAX)
    else $error("underflow flag missed a wrap");
  a_irq_gate:
    assert property (@(posedge clk) disable iff (!rst_n) irq_req == $past(flags & irq_enable))
    else $error("interrupt request not gated by flag and enable");
  a_dma_clear:
    assert property (@(posedge clk) disable iff (!rst_n)
      dma_ack && dma_request_select == 2'h0 && !capture_strobe[0] && !(gr_is_compare[0] && stepped[0])
      |=> !flags[0][`PU_BIT_FLAG_A])
    else $error("DMA acknowledge did not clear flag A");
  a_counter_write:
    assert property (@(posedge clk) disable iff (!rst_n) cnt_wr[0] |=> cnt[0] == $past(bus_wdata))
    else $error("counter write not taken");
  a_byte_write_ignored:
    assert property (@(posedge clk) disable iff (!rst_n)
      bus_wr && bus_size == SIZE_BYTE && bus_addr == `PU_IDX_COUNT_CH0 && !(run_bit[0] && count_tick[0])
      |=> cnt[0] == $past(cnt[0]))
    else $error("byte write changed a counter");

  // Read path: data stands between reads and shows what was sampled on the read edge
  a_rdata_stands:
    assert property (@(posedge clk) disable iff (!rst_n)
      !bus_rd |=> bus_rdata == $past(bus_rdata))
    else $error("read data changed without a read");
  a_status_upper_zero:
    assert property (@(posedge clk) disable iff (!rst_n)
      bus_rd && bus_addr <= `PU_IDX_STATUS_CH2 |=> bus_rdata[15:8] == 8'h00)
    else $error("status read drove the upper byte");
  a_ch0_flags_read:
    assert property (@(posedge clk) disable iff (!rst_n)
      bus_rd && bus_addr == `PU_IDX_STATUS_CH0 |=> bus_rdata[4:0] == $past(flags[0][4:0]))
    else $error("channel 0 flags read wrong");
  a_ch1_status_read:
    assert property (@(posedge clk) disable iff (!rst_n)
      bus_rd && bus_addr == `PU_IDX_STATUS_CH1 |=> bus_rdata[7] == $past(dir[1]) && bus_rdata[5:4] == $past(flags[1][5:4]))
    else $error("channel 1 status read wrong");
  a_ch2_status_read:
    assert property (@(posedge clk) disable iff (!rst_n)
      bus_rd && bus_addr == `PU_IDX_STATUS_CH2 |=> bus_rdata[7] == $past(dir[2]) && bus_rdata[5:4] == $past(flags[2][5:4]))
    else $error("channel 2 status read wrong");
  a_count_read_ch0:
    assert property (@(posedge clk) disable iff (!rst_n)
      bus_rd && bus_addr == `PU_IDX_COUNT_CH0 |=> bus_rdata == $past(cnt[0]))
    else $error("channel 0 counter read wrong");
  a_count_read_ch1:
    assert property (@(posedge clk) disable iff (!rst_n)
      bus_rd && bus_addr == `PU_IDX_COUNT_CH1 |=> bus_rdata == $past(cnt[1]))
    else $error("channel 1 counter read wrong");
  a_count_read_ch2:
    assert property (@(posedge clk) disable iff (!rst_n)
      bus_rd && bus_addr == `PU_IDX_COUNT_CH2 |=> bus_rdata == $past(cnt[2]))
    else $error("channel 2 counter read wrong");
  a_unmapped_read:
    assert property (@(posedge clk) disable iff (!rst_n)
      bus_rd && bus_addr > `PU_IDX_COUNT_CH2 |=> bus_rdata == 16'h0000)
    else $error("unmapped index did not read zero");

  // Direction bit: fixed up on channel 0 and outside phase mode, follows the step inside it
  a_ch0_dir_fixed:
    assert property (@(posedge clk) disable iff (!rst_n) dir[0])
    else $error("channel 0 direction bit not one");
  a_dir_up_ch1:
    assert property (@(posedge clk) disable iff (!rst_n)
      !phase_mode[0] |=> dir[1])
    else $error("channel 1 direction not up outside phase mode");
  a_dir_up_ch2:
    assert property (@(posedge clk) disable iff (!rst_n)
      !phase_mode[1] |=> dir[2])
    else $error("channel 2 direction not up outside phase mode");
  a_dir_down_ch1:
    assert property (@(posedge clk) disable iff (!rst_n)
      phase_mode[0] && phase_down[0] && run_bit[1] && count_tick[1] && !cnt_wr[1] |=> !dir[1])
    else $error("channel 1 direction not down after a down step");
  a_dir_down_ch2:
    assert property (@(posedge clk) disable iff (!rst_n)
      phase_mode[1] && phase_down[1] && run_bit[2] && count_tick[2] && !cnt_wr[2] |=> !dir[2])
    else $error("channel 2 direction not down after a down step");

  // Counting: direction per mode, and no movement while stopped
  a_ch0_up_only:
    assert property (@(posedge clk) disable iff (!rst_n)
      run_bit[0] && count_tick[0] && !cnt_wr[0] |=> cnt[0] == $past(cnt[0]) + `PU_COUNT_ONE)
    else $error("channel 0 did not count up");
  a_ch1_down_step:
    assert property (@(posedge clk) disable iff (!rst_n)
      phase_mode[0] && phase_down[0] && run_bit[1] && count_tick[1] && !cnt_wr[1]
      |=> cnt[1] == $past(cnt[1]) - `PU_COUNT_ONE)
    else $error("channel 1 did not count down");
  a_ch2_down_step:
    assert property (@(posedge clk) disable iff (!rst_n)
      phase_mode[1] && phase_down[1] && run_bit[2] && count_tick[2] && !cnt_wr[2]
      |=> cnt[2] == $past(cnt[2]) - `PU_COUNT_ONE)
    else $error("channel 2 did not count down");
  a_ch1_up_plain:
    assert property (@(posedge clk) disable iff (!rst_n)
      !phase_mode[0] && run_bit[1] && count_tick[1] && !cnt_wr[1] |=> cnt[1] == $past(cnt[1]) + `PU_COUNT_ONE)
    else $error("channel 1 did not count up outside phase mode");
  a_ch0_stopped:
    assert property (@(posedge clk) disable iff (!rst_n)
      !run_bit[0] && !cnt_wr[0] |=> cnt[0] == $past(cnt[0]))
    else $error("channel 0 counter moved while stopped");

  // Flag setting events
  a_ch0_overflow:
    assert property (@(posedge clk) disable iff (!rst_n)
      wrap_up[0] |=> flags[0][`PU_BIT_OVERFLOW] && cnt[0] == `PU_COUNT_RESET)
    else $error("channel 0 overflow not flagged or not restarted from zero");
  a_ch1_underflow:
    assert property (@(posedge clk) disable iff (!rst_n)
      wrap_down[1] |=> flags[1][`PU_BIT_UNDERFLOW] && cnt[1] == `PU_COUNT_MAX)
    else $error("channel 1 underflow not flagged");
  a_ch0_match_a:
    assert property (@(posedge clk) disable iff (!rst_n)
      gr_is_compare[0] && stepped[0] && cnt[0] == gr_value[15:0] |=> flags[0][`PU_BIT_FLAG_A])
    else $error("compare match A not flagged");
  a_ch0_match_b:
    assert property (@(posedge clk) disable iff (!rst_n)
      gr_is_compare[1] && stepped[0] && cnt[0] == gr_value[31:16] |=> flags[0][1])
    else $error("compare match B not flagged");
  a_ch0_match_d:
    assert property (@(posedge clk) disable iff (!rst_n)
      gr_is_compare[3] && stepped[0] && cnt[0] == gr_value[63:48] |=> flags[0][`PU_BIT_FLAG_D])
    else $error("compare match D not flagged");
  a_ch1_capture_a:
    assert property (@(posedge clk) disable iff (!rst_n)
      !gr_is_compare[4] && capture_strobe[4] |=> flags[1][0])
    else $error("channel 1 capture A not flagged");
  a_ch2_capture_a:
    assert property (@(posedge clk) disable iff (!rst_n)
      !gr_is_compare[6] && capture_strobe[6] |=> flags[2][0])
    else $error("channel 2 capture A not flagged");

  // Clearing by DMA, reserved requests and word writes
  a_dma_clear_b:
    assert property (@(posedge clk) disable iff (!rst_n)
      dma_ack && dma_request_select == 2'h1 && !capture_strobe[1] && !(gr_is_compare[1] && stepped[0])
      |=> !flags[0][1])
    else $error("DMA acknowledge did not clear flag B");
  a_irq_reserved:
    assert property (@(posedge clk) disable iff (!rst_n)
      !irq_req[5] && irq_req[9:8] == 2'h0 && irq_req[15:14] == 2'h0)
    else $error("request raised on a reserved bit");
  a_cnt_write_ch1:
    assert property (@(posedge clk) disable iff (!rst_n)
      cnt_wr[1] |=> cnt[1] == $past(bus_wdata))
    else $error("channel 1 counter write not taken");
endmodule // timer_channel_status_and_counter
`default_nettype wire

/* verif/dma_partner.sv */
// Behavioural DMA controller answering the selected channel 0 compare/capture request
`timescale 1ns/10ps
`default_nettype none
module dma_partner (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic en,
  input wire logic [3:0] req,
  input wire logic [1:0] sel,
  input wire logic [3:0] lag,
  output logic ack
);
  logic [3:0] wait_r;
  logic busy_r;
  // One transfer per request after lag cycles; waits for the request to drop so it never acks twice
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
    begin
      wait_r <= 4'h0;
      busy_r <= 1'b0;
      ack <= 1'b0;
    end
    else
    begin
      ack <= 1'b0;
      if (busy_r)
        busy_r <= req[sel];
      else if (en && req[sel])
      begin
        wait_r <= (wait_r == lag) ? 4'h0 : wait_r + 4'h1;
        ack <= (wait_r == lag);
        busy_r <= (wait_r == lag);
      end
    end
endmodule // dma_partner
`default_nettype wire

/* verif/testbench.sv */
// Self-checking bench for the timer channel status flags and counters
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import pulse_unit_pkg::*;
  logic clk, rst_n, bus_rd, bus_wr, dma_ack, dma_en;
  logic [2:0] bus_addr, run_bit, count_tick;
  access_size_t bus_size;
  logic [15:0] bus_wdata, bus_rdata;
  logic [1:0] phase_mode, phase_down, dma_request_select;
  logic [127:0] gr_value;
  logic [7:0] gr_is_compare, capture_strobe;
  logic [17:0] irq_enable, irq_req;
  logic [3:0] lag;
  int miscompares, compares, cycles;

  timer_channel_status_and_counter DUT (.clk(clk), .rst_n(rst_n), .bus_addr(bus_addr), .bus_rd(bus_rd),
    .bus_wr(bus_wr), .bus_size(bus_size), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata), .run_bit(run_bit),
    .count_tick(count_tick), .phase_mode(phase_mode), .phase_down(phase_down), .gr_value(gr_value),
    .gr_is_compare(gr_is_compare), .capture_strobe(capture_strobe), .irq_enable(irq_enable),
    .dma_ack(dma_ack), .dma_request_select(dma_request_select), .irq_req(irq_req));
  dma_partner partner (.clk(clk), .rst_n(rst_n), .en(dma_en), .req(irq_req[3:0]), .sel(dma_request_select),
    .lag(lag), .ack(dma_ack));

  // Free-running 40 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    chk({15'h0, got}, {15'h0, exp});
  endtask

  // Write strobe for one cycle; an optional tick lands on the same edge to race a clear
  task automatic wr(input logic [2:0] a, input logic [15:0] d, input access_size_t sz = SIZE_WORD,
                    input logic [2:0] tk = 3'h0);
    @(posedge clk);
    bus_wr <= 1'b1; bus_addr <= a; bus_wdata <= d; bus_size <= sz; count_tick <= tk;
    @(posedge clk);
    bus_wr <= 1'b0; count_tick <= 3'h0;
  endtask

  // Read strobe for one cycle; data is looked at one edge after it settles
  task automatic rd_chk(input logic [2:0] a, input logic [15:0] exp);
    @(posedge clk);
    bus_rd <= 1'b1; bus_addr <= a; bus_size <= SIZE_WORD;
    @(posedge clk);
    bus_rd <= 1'b0;
    @(posedge clk);
    chk(bus_rdata, exp);
  endtask

  task automatic tick(input int ch);
    @(posedge clk);
    count_tick <= 3'h1 << ch;
    @(posedge clk);
    count_tick <= 3'h0;
  endtask

  task automatic tally_and_finish;
    if (miscompares == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Hang guard: the whole sequence needs well under a thousand cycles
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      miscompares++;
      tally_and_finish;
    end
  end

  initial
  begin
    rst_n = 1'b0; bus_rd = 1'b0; bus_wr = 1'b0; bus_addr = 3'h0; bus_size = SIZE_WORD; bus_wdata = 16'h0;
    run_bit = 3'h0; count_tick = 3'h0; phase_mode = 2'h0; phase_down = 2'h0; capture_strobe = 8'h0;
    gr_value = {64'hffff_ffff_ffff_ffff, 64'h0013_0012_0011_0010};
    gr_is_compare = 8'h0f; irq_enable = 18'h0; dma_en = 1'b0; dma_request_select = 2'h0; lag = 4'h0;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 3; i++) rd_chk(i[2:0], 16'h00c0);
    for (int i = 3; i < 7; i++) rd_chk(i[2:0], 16'h0000);
    // Ones into reserved bits and zeros into fixed bits must leave the reset value
    for (int i = 0; i < 3; i++)
    begin
      wr(i[2:0], 16'h002c);
      rd_chk(i[2:0], 16'h00c0);
    end
    irq_enable <= 18'h00810;
    run_bit <= 3'h7;
    wr(3'h3, 16'hffff);
    wr(3'h3, 16'h0012, SIZE_BYTE);
    rd_chk(3'h3, 16'hffff);
    tick(0);
    wr(3'h0, 16'h00ef);
    rd_chk(3'h0, 16'h00d0);
    chk_bit(irq_req[4], 1'b1);
    wr(3'h0, 16'h00ff);
    rd_chk(3'h0, 16'h00d0);
    wr(3'h0, 16'h00ef);
    rd_chk(3'h0, 16'h00c0);
    chk_bit(irq_req[4], 1'b0);
    tick(0);
    rd_chk(3'h3, 16'h0001);
    run_bit <= 3'h6;
    tick(0);
    rd_chk(3'h3, 16'h0001);
    run_bit <= 3'h7;
    // A fresh overflow on the clearing edge must survive the clear
    wr(3'h3, 16'hffff);
    tick(0);
    rd_chk(3'h0, 16'h00d0);
    wr(3'h3, 16'hffff);
    wr(3'h0, 16'h00ef, SIZE_WORD, 3'h1);
    rd_chk(3'h0, 16'h00d0);
    wr(3'h0, 16'h00ef);
    wr(3'h3, 16'h000f);
    repeat (4) tick(0);
    rd_chk(3'h0, 16'h00cf);
    // DMA takes flags A to D one by one, answering promptly and then slower
    irq_enable <= 18'h0081f;
    for (int s = 0; s < 4; s++)
    begin
      dma_request_select <= s[1:0]; lag <= s[3:0]; dma_en <= 1'b1;
      repeat (12) @(posedge clk);
      dma_en <= 1'b0;
      rd_chk(3'h0, 16'h00c0 | (16'h000f & (16'h000f << (s + 1))));
    end
    wr(3'h4, 16'h0000);
    phase_mode <= 2'h1; phase_down <= 2'h1;
    tick(1);
    rd_chk(3'h4, 16'hffff);
    rd_chk(3'h1, 16'h0060);
    chk_bit(irq_req[11], 1'b1);
    phase_mode <= 2'h0;
    tick(1);
    rd_chk(3'h4, 16'h0000);
    rd_chk(3'h1, 16'h00f0);
    chk_bit(irq_req[10], 1'b0);
    @(posedge clk);
    capture_strobe <= 8'h50;
    @(posedge clk);
    capture_strobe <= 8'h00;
    rd_chk(3'h1, 16'h00f1);
    rd_chk(3'h2, 16'h00c1);
    // Channel 2 steps down through zero in phase mode, then a byte write clears its flag A
    phase_mode <= 2'h2;
    phase_down <= 2'h2;
    tick(2);
    rd_chk(3'h5, 16'hffff);
    rd_chk(3'h2, 16'h0061);
    wr(3'h2, 16'h00fe, SIZE_BYTE);
    rd_chk(3'h2, 16'h0060);
    tally_and_finish;
  end
endmodule // testbench
`default_nettype wire
